// ==== rtl/cidrx_pkg.sv ====
// Shared constants and state carriers for the caller-id receiver control logic
package cidrx_pkg;

    // System clock
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;

    // Counter width, wide enough for the longest timing count
    localparam int unsigned CNT_W          = 24;

    // Printed times
    localparam int unsigned T_OSC_START_MS = 2;
    localparam int unsigned T_SETUP_MS     = 15;
    localparam int unsigned T_ACQ_MS       = 14;
    localparam int unsigned T_HOLD_MS      = 8;
    localparam int unsigned T_RESET_US     = 10;

    // Demodulated stream
    localparam int unsigned BAUD_BPS       = 1200;
    localparam int unsigned MARK_HZ        = 1200;
    localparam int unsigned SPACE_HZ       = 2200;
    localparam logic        MARK_LEVEL     = 1'b1;
    localparam logic        SPACE_LEVEL    = 1'b0;
    localparam int unsigned MARK_QUAL_BITS = 10;

    // Derived cycle counts: typical figures truncate, least figures round up
    localparam int unsigned OSC_START_CYC  = T_OSC_START_MS * CLK_PER_MS;
    localparam int unsigned ACQ_CYC        = T_ACQ_MS * CLK_PER_MS;
    localparam int unsigned HOLD_CYC       = T_HOLD_MS * CLK_PER_MS;
    localparam int unsigned BIT_CYC        = (CLK_HZ + BAUD_BPS - 1) / BAUD_BPS;
    localparam int unsigned MARK_QUAL_CYC  = MARK_QUAL_BITS * BIT_CYC;

    // Divider ratios presented to the oscillator divider; values are plain defaults
    localparam logic [7:0]  DIV_CRYSTAL    = 8'h08;
    localparam logic [7:0]  DIV_RESONATOR  = 8'h01;

    // Power modes
    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_RING_CHECK,
        MODE_OSC_START,
        MODE_ACTIVE
    } cidrx_mode_type;

    // Open-drain pin drive
    typedef struct packed {
        logic o;
        logic oe;
    } cidrx_od_type;

    // Whole state of the control block
    typedef struct packed {
        cidrx_mode_type   mode;
        logic [CNT_W-1:0] osc_cnt;
        logic [CNT_W-1:0] acq_cnt;
        logic [CNT_W-1:0] rel_cnt;
        logic [CNT_W-1:0] mark_cnt;
        logic             ring_valid;
        logic             car_valid;
        logic             validated;
        logic             unf;
        logic             val;
        logic [7:0]       div_ratio;
    } cidrx_state_type;

    localparam cidrx_state_type STATE_RESET = '{
        mode:       MODE_STANDBY,
        osc_cnt:    '0,
        acq_cnt:    '0,
        rel_cnt:    '0,
        mark_cnt:   '0,
        ring_valid: 1'b0,
        car_valid:  1'b0,
        validated:  1'b0,
        unf:        1'b1,
        val:        1'b1,
        div_ratio:  DIV_RESONATOR
    };

endpackage

// ==== rtl/cidrx_ctrl.sv ====
// Power, ring, carrier and data-gating control of the caller-id receiver
// Overview of operation
// - Wake request low enters active mode
// - Wake high and ring timer high: standby
// - Range select picks crystal or resonator divider
// - Ring-valid low while valid ringing persists
// - Carrier-valid low while carrier stays valid
// - Carrier release delayed by 8 ms hysteresis
// - Raw data passes only while carrier valid
// - Raw data includes seizure and mark period
// - Validated data only after mark-run validation
// - Ring timer low wakes ring judging only
// - Primary ring energy enables oscillator, ring logic
// - Carrier acquired in 14 ms, held 8 ms
// - Stream 1200 bps, mark one, space zero
`timescale 1ns/1ps

module cidrx_ctrl #(
    parameter logic [23:0] OSC_START_CYC = 24'(cidrx_pkg::OSC_START_CYC),
    parameter logic [23:0] ACQ_CYC       = 24'(cidrx_pkg::ACQ_CYC),
    parameter logic [23:0] HOLD_CYC      = 24'(cidrx_pkg::HOLD_CYC),
    parameter logic [23:0] MARK_QUAL_CYC = 24'(cidrx_pkg::MARK_QUAL_CYC)
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    // Power control pins
    input  wire logic                 wake_request_n,
    input  wire logic                 ring_timer_node,
    input  wire logic                 osc_range_sel,
    // Ring sensing
    input  wire logic                 ring_sense_primary,
    input  wire logic                 ring_sense_precise,
    // From the analog demodulator
    input  wire logic                 demod_bit,
    input  wire logic                 carrier_present,
    // Open-drain indications
    output cidrx_pkg::cidrx_od_type   ring_valid_n,
    output cidrx_pkg::cidrx_od_type   carrier_valid_n,
    // Serial data
    output logic                      demod_unfiltered,
    output logic                      demod_validated,
    // Power and clock status
    output logic                      osc_enable,
    output logic                      ring_logic_enable,
    output logic                      receiver_active,
    output logic [7:0]                osc_div_ratio
);

    cidrx_pkg::cidrx_state_type st;
    cidrx_pkg::cidrx_state_type next_st;

    logic ring_en;
    logic active_now;

    // Saturating-at-limit match used by every timing counter
    function automatic logic at_limit(input logic [23:0] cnt, input logic [23:0] lim);
        at_limit = (cnt >= lim - 24'h000001);
    endfunction

    // Ring judging needs only the ring timer or primary energy, not the full receiver
    assign ring_en = (st.mode != cidrx_pkg::MODE_STANDBY) || ring_sense_primary;
    assign active_now = (st.mode == cidrx_pkg::MODE_ACTIVE);

    always_comb begin
        next_st = st;

        // Power mode sequencing
        case (st.mode)
            cidrx_pkg::MODE_STANDBY,
            cidrx_pkg::MODE_RING_CHECK: begin
                next_st.osc_cnt = '0;
                if (!wake_request_n) begin
                    next_st.mode = cidrx_pkg::MODE_OSC_START;
                end else if (!ring_timer_node) begin
                    next_st.mode = cidrx_pkg::MODE_RING_CHECK;
                end else begin
                    next_st.mode = cidrx_pkg::MODE_STANDBY;
                end
            end
            cidrx_pkg::MODE_OSC_START: begin
                if (wake_request_n) begin
                    next_st.osc_cnt = '0;
                    next_st.mode = ring_timer_node ? cidrx_pkg::MODE_STANDBY
                                                   : cidrx_pkg::MODE_RING_CHECK;
                end else if (at_limit(st.osc_cnt, OSC_START_CYC)) begin
                    next_st.mode = cidrx_pkg::MODE_ACTIVE;
                end else begin
                    next_st.osc_cnt = st.osc_cnt + 24'h000001;
                end
            end
            cidrx_pkg::MODE_ACTIVE: begin
                if (wake_request_n) begin
                    next_st.osc_cnt = '0;
                    next_st.mode = ring_timer_node ? cidrx_pkg::MODE_STANDBY
                                                   : cidrx_pkg::MODE_RING_CHECK;
                end
            end
            default: begin
                next_st.mode = cidrx_pkg::MODE_STANDBY;
            end
        endcase

        // Divider follows the range pin continuously
        next_st.div_ratio = osc_range_sel ? cidrx_pkg::DIV_CRYSTAL
                                          : cidrx_pkg::DIV_RESONATOR;

        // Ring indication tracks the precise detector while ring logic is awake
        next_st.ring_valid = ring_en && ring_sense_precise;

        // Carrier qualification only runs in the full receiver
        if (!active_now) begin
            next_st.acq_cnt   = '0;
            next_st.rel_cnt   = '0;
            next_st.car_valid = 1'b0;
        end else if (carrier_present) begin
            next_st.rel_cnt = '0;
            if (!st.car_valid) begin
                if (at_limit(st.acq_cnt, ACQ_CYC)) begin
                    next_st.car_valid = 1'b1;
                    next_st.acq_cnt   = '0;
                end else begin
                    next_st.acq_cnt = st.acq_cnt + 24'h000001;
                end
            end
        end else begin
            next_st.acq_cnt = '0;
            if (st.car_valid) begin
                // A short dropout keeps the indication; only a full hold time without carrier releases
                if (at_limit(st.rel_cnt, HOLD_CYC)) begin
                    next_st.car_valid = 1'b0;
                    next_st.rel_cnt   = '0;
                end else begin
                    next_st.rel_cnt = st.rel_cnt + 24'h000001;
                end
            end
        end

        // Validation: a mark run longer than any seizure bit ends the alternating pattern
        if (!next_st.car_valid) begin
            next_st.validated = 1'b0;
            next_st.mark_cnt  = '0;
        end else if (!st.validated) begin
            if (demod_bit == cidrx_pkg::MARK_LEVEL) begin
                if (at_limit(st.mark_cnt, MARK_QUAL_CYC)) begin
                    next_st.validated = 1'b1;
                end else begin
                    next_st.mark_cnt = st.mark_cnt + 24'h000001;
                end
            end else begin
                next_st.mark_cnt = '0;
            end
        end

        // Output gating; space reaches the pins as zero, idle as mark
        next_st.unf = next_st.car_valid ? demod_bit : cidrx_pkg::MARK_LEVEL;
        next_st.val = (next_st.car_valid && next_st.validated) ? demod_bit
                                                               : cidrx_pkg::MARK_LEVEL;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= cidrx_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Open-drain: only ever pull low, release otherwise
    assign ring_valid_n.o     = 1'b0;
    assign ring_valid_n.oe    = st.ring_valid;
    assign carrier_valid_n.o  = 1'b0;
    assign carrier_valid_n.oe = st.car_valid;

    assign demod_unfiltered  = st.unf;
    assign demod_validated   = st.val;
    assign osc_enable        = ring_en;
    assign ring_logic_enable = ring_en;
    assign receiver_active   = active_now;
    assign osc_div_ratio     = st.div_ratio;

    // Checks on the control behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_osc_last;
        st.mode == cidrx_pkg::MODE_OSC_START && at_limit(st.osc_cnt, OSC_START_CYC);
    endsequence

    sequence s_wake_held;
        !wake_request_n;
    endsequence

    sequence s_osc_counting;
        st.mode == cidrx_pkg::MODE_OSC_START && !at_limit(st.osc_cnt, OSC_START_CYC);
    endsequence

    a_wake_enters_start: assert property (
        (st.mode == cidrx_pkg::MODE_STANDBY && !wake_request_n)
        |=> st.mode == cidrx_pkg::MODE_OSC_START)
        else $error("wake request did not start oscillator");

    a_standby_entry: assert property (
        (wake_request_n && ring_timer_node) |=> st.mode == cidrx_pkg::MODE_STANDBY)
        else $error("standby not entered");

    a_div_select: assert property (
        !srst |=> osc_div_ratio == ($past(osc_range_sel) ? cidrx_pkg::DIV_CRYSTAL
                                                   : cidrx_pkg::DIV_RESONATOR))
        else $error("divider ratio does not follow range select");

    a_ring_follow: assert property (
        (ring_en && ring_sense_precise) |=> ring_valid_n.oe && !ring_valid_n.o)
        else $error("ring valid not driven low");

    a_ring_release: assert property (
        !ring_sense_precise |=> !ring_valid_n.oe)
        else $error("ring valid held without ringing");

    a_car_acquire: assert property (
        $rose(carrier_valid_n.oe) |-> $past(st.acq_cnt) == ACQ_CYC - 24'h000001)
        else $error("carrier valid asserted at wrong acquisition count");

    a_car_hold: assert property (
        // A reset also drops the indication; that is not a hold release
        ($fell(carrier_valid_n.oe) && $past(active_now) && !$past(srst))
        |-> $past(st.rel_cnt) == HOLD_CYC - 24'h000001 && !$past(carrier_present))
        else $error("carrier valid released before hold time");

    a_car_stays: assert property (
        (carrier_valid_n.oe && active_now && carrier_present) |=> carrier_valid_n.oe)
        else $error("carrier valid dropped while carrier present");

    a_raw_idle_high: assert property (
        !carrier_valid_n.oe |-> demod_unfiltered)
        else $error("raw data not high without carrier");

    a_raw_passes: assert property (
        carrier_valid_n.oe |-> demod_unfiltered == $past(demod_bit))
        else $error("raw data does not follow demodulator");

    a_val_gated: assert property (
        !st.validated |-> demod_validated)
        else $error("validated data active before validation");

    a_val_needs_mark: assert property (
        $rose(st.validated) |-> $past(demod_bit) && $past(st.validated) == 1'b0
        && $past(st.mark_cnt) == MARK_QUAL_CYC - 24'h000001)
        else $error("validation passed without full mark run");

    a_ring_check_partial: assert property (
        st.mode == cidrx_pkg::MODE_RING_CHECK |-> ring_logic_enable && !receiver_active)
        else $error("ring timer woke full receiver");

    a_primary_enables: assert property (
        ring_sense_primary |-> osc_enable && ring_logic_enable)
        else $error("primary ring energy did not enable oscillator");

    a_osc_startup: assert property (
        s_osc_last ##0 s_wake_held |=> receiver_active)
        else $error("receiver not active after start-up delay");

    a_no_early_active: assert property (
        $rose(receiver_active) |-> $past(st.osc_cnt) == OSC_START_CYC - 24'h000001)
        else $error("receiver active before oscillator settled");

    a_active_holds: assert property (
        (receiver_active && !wake_request_n) |=> receiver_active)
        else $error("receiver left active mode while wake held");

    a_ring_check_entry: assert property (
        (st.mode == cidrx_pkg::MODE_STANDBY && wake_request_n && !ring_timer_node)
        |=> st.mode == cidrx_pkg::MODE_RING_CHECK)
        else $error("ring timer did not wake ring judging");

    a_start_abort: assert property (
        (st.mode == cidrx_pkg::MODE_OSC_START && wake_request_n)
        |=> !receiver_active && st.osc_cnt == '0)
        else $error("withdrawn wake did not abort start-up");

    a_osc_count_step: assert property (
        s_osc_counting ##0 s_wake_held
        |=> st.osc_cnt == $past(st.osc_cnt) + 24'h000001)
        else $error("start-up counter did not advance");

    a_car_needs_active: assert property (
        !active_now |=> !carrier_valid_n.oe)
        else $error("carrier valid outside active mode");

    a_acq_restart: assert property (
        !carrier_present |=> st.acq_cnt == '0)
        else $error("acquisition count survived a carrier gap");

    a_hold_restart: assert property (
        carrier_present |=> st.rel_cnt == '0)
        else $error("hold count survived returning carrier");

    a_val_follows: assert property (
        (st.validated && carrier_valid_n.oe) |-> demod_validated == $past(demod_bit))
        else $error("validated data does not follow demodulator");

endmodule

// ==== tb/cidrx_line_model.sv ====
// Line-side model: carrier energy and demodulated bit stream fed to the receiver
`timescale 1ns/1ps

module cidrx_line_model #(
    parameter int BIT_CYC = 4
) (
    // Clock
    input  wire logic       clk_sys,
    // Control from the bench
    input  wire logic       line_on,
    input  wire logic [1:0] pattern,
    // Towards the receiver
    output logic            carrier_present,
    output logic            demod_bit
);
    int seed  = 44;
    int phase = 0;

    initial begin
        carrier_present = 1'b0;
        demod_bit       = 1'b0;
    end

    // Bit time shortened so that a whole call fits a short run
    always @(posedge clk_sys) begin
        phase           <= (phase + 1) % BIT_CYC;
        carrier_present <= line_on;
        if (!line_on) begin
            // No carrier: the stream means nothing, so keep it moving
            demod_bit <= ~demod_bit;
        end else if (phase == 0) begin
            case (pattern)
                2'h0: demod_bit <= ~demod_bit;
                2'h1: demod_bit <= 1'b1;
                default: demod_bit <= 1'($random(seed));
            endcase
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the caller-id receiver control block
`timescale 1ns/1ps

module testbench;
    localparam logic [23:0] OSC_N  = 24'h000014;
    localparam logic [23:0] ACQ_N  = 24'h000028;
    localparam logic [23:0] HOLD_N = 24'h00001e;
    localparam logic [23:0] QUAL_N = 24'h000032;
    // Setup time scaled by the same factor as the shortened start-up count
    localparam int SETUP_N = int'(OSC_N) * cidrx_pkg::T_SETUP_MS / cidrx_pkg::T_OSC_START_MS;
    localparam int RESET_N = cidrx_pkg::T_RESET_US * cidrx_pkg::CLK_PER_MS / 1000;

    logic                    clk_sys = 1'b0;
    logic                    srst = 1'b1;
    logic                    wake_request_n = 1'b1;
    logic                    ring_timer_node = 1'b1;
    logic                    osc_range_sel = 1'b0;
    logic                    ring_sense_primary = 1'b0;
    logic                    ring_sense_precise = 1'b0;
    logic                    line_on = 1'b0;
    logic [1:0]              pattern = 2'h0;
    logic                    carrier_present;
    logic                    demod_bit;
    logic                    demod_unfiltered;
    logic                    demod_validated;
    logic                    osc_enable;
    logic                    ring_logic_enable;
    logic                    receiver_active;
    logic [7:0]              osc_div_ratio;
    cidrx_pkg::cidrx_od_type ring_valid_n;
    cidrx_pkg::cidrx_od_type carrier_valid_n;
    int                      error_cnt = 0;
    int                      cmp_count = 0;
    int                      seed = 44;
    int                      cnt;
    logic                    pb;
    logic                    ps;
    logic                    pr;

    always #10 clk_sys = ~clk_sys;

    cidrx_line_model line (.clk_sys(clk_sys), .line_on(line_on), .pattern(pattern),
        .carrier_present(carrier_present), .demod_bit(demod_bit));

    cidrx_ctrl #(.OSC_START_CYC(OSC_N), .ACQ_CYC(ACQ_N), .HOLD_CYC(HOLD_N),
        .MARK_QUAL_CYC(QUAL_N)) uut (.clk_sys(clk_sys), .srst(srst),
        .wake_request_n(wake_request_n), .ring_timer_node(ring_timer_node),
        .osc_range_sel(osc_range_sel), .ring_sense_primary(ring_sense_primary),
        .ring_sense_precise(ring_sense_precise), .demod_bit(demod_bit),
        .carrier_present(carrier_present), .ring_valid_n(ring_valid_n),
        .carrier_valid_n(carrier_valid_n), .demod_unfiltered(demod_unfiltered),
        .demod_validated(demod_validated), .osc_enable(osc_enable),
        .ring_logic_enable(ring_logic_enable), .receiver_active(receiver_active),
        .osc_div_ratio(osc_div_ratio));

    function automatic logic [7:0] exp_div(input logic sel);
        return sel ? 8'h08 : 8'h01;
    endfunction

    function automatic logic [7:0] in_range(input int v, input int lo, input int hi);
        return 8'((v >= lo) && (v <= hi));
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Inputs are captured before the edge's updates land, outputs judged at the falling edge
    task automatic cap();
        @(posedge clk_sys);
        pb = demod_bit;
        ps = ring_sense_precise;
        pr = osc_range_sel;
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #(20 * 6000);
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
        chk(8'({carrier_valid_n.oe, ring_valid_n.oe, receiver_active}), 8'h00);
        chk(8'({demod_unfiltered, demod_validated}), 8'h03);
        chk(osc_div_ratio, 8'h01);
        chk(8'({ring_valid_n.o, carrier_valid_n.o}), 8'h00);
        // Wake and ring timer stay high through the power-on interval
        repeat (RESET_N) @(posedge clk_sys);
        repeat (12) begin
            cap();
            osc_range_sel <= 1'($random(seed));
            @(negedge clk_sys);
            chk(osc_div_ratio, exp_div(pr));
        end
        @(posedge clk_sys);
        ring_timer_node    <= 1'b0;
        ring_sense_primary <= 1'b1;
        repeat (20) begin
            cap();
            ring_sense_precise <= 1'($random(seed));
            @(negedge clk_sys);
            chk(8'(ring_valid_n.oe), 8'(ps));
            chk(8'({osc_enable, ring_logic_enable}), 8'h03);
            chk(8'(receiver_active), 8'h00);
            chk(8'({ring_valid_n.o, carrier_valid_n.o}), 8'h00);
        end
        @(posedge clk_sys);
        ring_sense_precise <= 1'b0;
        ring_sense_primary <= 1'b0;
        ring_timer_node    <= 1'b1;
        wake_request_n     <= 1'b0;
        // Wake withdrawn during oscillator start-up must not reach active mode
        repeat (5) @(posedge clk_sys);
        wake_request_n <= 1'b1;
        repeat (OSC_N + 5) @(negedge clk_sys);
        chk(8'(receiver_active), 8'h00);
        @(posedge clk_sys);
        wake_request_n <= 1'b0;
        for (cnt = 0; receiver_active !== 1'b1 && cnt < 200; cnt++) @(negedge clk_sys);
        chk(in_range(cnt, OSC_N + 1, OSC_N + 3), 8'h01);
        repeat (SETUP_N - OSC_N) @(posedge clk_sys);
        @(posedge clk_sys);
        line_on <= 1'b1;
        for (cnt = 0; carrier_valid_n.oe !== 1'b1 && cnt < 200; cnt++) @(negedge clk_sys);
        chk(in_range(cnt, ACQ_N + 1, ACQ_N + 4), 8'h01);
        repeat (40) begin
            cap();
            @(negedge clk_sys);
            chk(8'(demod_unfiltered), 8'(pb));
            chk(8'(demod_validated), 8'h01);
        end
        @(posedge clk_sys);
        pattern <= 2'h1;
        repeat (QUAL_N + 10) @(posedge clk_sys);
        pattern <= 2'h2;
        repeat (40) begin
            cap();
            @(negedge clk_sys);
            chk(8'({demod_unfiltered, demod_validated}), 8'({pb, pb}));
        end
        @(posedge clk_sys);
        line_on <= 1'b0;
        repeat (int'($unsigned($random(seed)) % 16) + 1) @(posedge clk_sys);
        line_on <= 1'b1;
        repeat (40) begin
            @(negedge clk_sys);
            chk(8'(carrier_valid_n.oe), 8'h01);
        end
        @(posedge clk_sys);
        line_on <= 1'b0;
        for (cnt = 0; carrier_valid_n.oe !== 1'b0 && cnt < 200; cnt++) @(negedge clk_sys);
        chk(in_range(cnt, HOLD_N + 1, HOLD_N + 4), 8'h01);
        repeat (10) begin
            @(negedge clk_sys);
            chk(8'({demod_unfiltered, demod_validated}), 8'h03);
        end
        @(posedge clk_sys);
        wake_request_n <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(8'({receiver_active, osc_enable}), 8'h00);
        finish_test();
    end
endmodule
